//--- verilog/boot_load_pkg.sv
// Purpose: Shared constants and types for the boot-load sequencer
// Assumes: One 125 MHz clock, synchronous active-low reset
// Notes:   Command codes and variant codes are local encodings
package boot_load_pkg;
    localparam int          CLK_MHZ           = 125;
    localparam int          RECORD_COUNT      = 16;
    localparam int          REC_W             = 5;
    localparam logic [7:0]  START_CYLINDER    = 8'h00;
    localparam logic [3:0]  START_HEAD        = 4'h0;
    localparam logic [7:0]  START_SECTOR      = 8'h01;
    localparam logic [7:0]  START_RECORD      = 8'h00;
    localparam logic [7:0]  MAGAZINE_NUMBER   = 8'h01;
    localparam logic [7:0]  MAGAZINE_SLOT     = 8'h01;
    localparam logic [7:0]  IO_SLOT           = 8'h01;
    localparam logic [15:0] STORE_START_ADDR  = 16'h0000;

    typedef enum logic [1:0] {
        VAR_FIXED_DISK,
        VAR_DISKETTE,
        VAR_MAGAZINE
    } variant_e;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_READ,
        CMD_RECALIBRATE,
        CMD_LOAD_HEADS,
        CMD_ORIENT,
        CMD_SELECT_MAGAZINE,
        CMD_SELECT_IO_SLOT
    } drive_cmd_e;
endpackage

//--- verilog/boot_store_addr.sv
// Purpose: Control-storage address counter for cycle-steal data moves
// Assumes: One byte per accepted beat
// Notes:   Restarts at the start address on every new boot load
`timescale 1ns/1ps
`default_nettype none
module boot_store_addr
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Control
    input  wire logic              restart,
    input  wire logic              advance,
    // Address
    output logic [ADDR_W-1:0]      addr
);
    import boot_load_pkg::*;

    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;

    // Refused at elaboration: the address must reach 4096 bytes
    if (ADDR_W < 12 || ADDR_W > 16)
    begin : g_bad_addr_w
        $error("boot_store_addr: ADDR_W out of range");
    end

    always_comb
    begin
        addr_next = addr_reg;
        if (restart)
            addr_next = STORE_START_ADDR[ADDR_W-1:0]; // [RULE_15]
        else if (advance)
            addr_next = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            addr_reg <= '0;
        else
            addr_reg <= addr_next;
    end

    assign addr = addr_reg;
endmodule
`default_nettype wire

//--- verilog/storage_boot_load_sequencer.sv
// Purpose: Adapter-side sequencer for boot program load from disk or diskette
// Assumes: Inputs synchronous to clk; drive answers each command other than read with cmd_done
// Notes:   Variant chosen by a static input; data forwarded byte by byte
//
// Functional notes
// [RULE_01] Fixed disk starts only after drive reset
// [RULE_02] Fixed disk waits request before any command
// [RULE_03] One read, 16 records, from record 0
// [RULE_04] Drive seeks cylinder 0, head 0, reads
// [RULE_05] Diskettes start only after power-on reset
// [RULE_06] Diskettes wait load request before commands
// [RULE_07] Diskettes issue fixed command series
// [RULE_08] Single diskette: recalibrate, load heads, read
// [RULE_09] Diskette read starts cylinder 0, head 0, sector 1
// [RULE_10] Magazine: orient first, before slot select
// [RULE_11] Select magazine 1 slot 1, else I/O slot 1; code sends the slot only, no magazine number
// [RULE_12] Magazine then recalibrate, load heads, read
// [RULE_13] Magazine read ends when request goes inactive
// [RULE_14] On completion hand control back to channel
// [RULE_15] Data cycle-stolen into storage from 0000
// [RULE_16] Channel counts 4096 bytes, drops load cycle
// [RULE_17] Fixed disk stops after sixteenth record, idles
`timescale 1ns/1ps
`default_nettype none
module storage_boot_load_sequencer
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // Configuration
    input  wire boot_load_pkg::variant_e  variant,
    // Drive reset levels
    input  wire logic                     drive_reset_n,
    input  wire logic                     power_on_reset_n,
    // Channel requests
    input  wire logic                     first_disk_boot_request_n,
    input  wire logic                     diskette_boot_request_n,
    input  wire logic                     microcode_load_cycle_n,
    // Drive command port
    output logic                          cmd_valid,
    output boot_load_pkg::drive_cmd_e     cmd_code,
    output logic [7:0]                    cmd_cylinder,
    output logic [3:0]                    cmd_head,
    output logic [7:0]                    cmd_sector,
    output logic [7:0]                    cmd_count,
    output logic [7:0]                    cmd_slot,
    input  wire logic                     cmd_ready,
    input  wire logic                     cmd_done,
    input  wire logic                     no_diskette,
    // Drive read data
    input  wire logic                     rd_valid,
    input  wire logic [7:0]               rd_data,
    input  wire logic                     rd_record_end,
    // Cycle-steal to control storage
    output logic                          cs_valid,
    output logic [7:0]                    cs_data,
    output logic [ADDR_W-1:0]             cs_addr,
    // Status
    output logic                          boot_busy,
    output logic                          boot_done
);
    import boot_load_pkg::*;

    typedef enum {
        ST_WAIT_RESET,
        ST_WAIT_REQUEST,
        ST_ISSUE,
        ST_WAIT_DONE,
        ST_READ,
        ST_FINISH
    } seq_state_e;

    if (ADDR_W < 12 || ADDR_W > 16)
    begin : g_bad_addr_w
        $error("storage_boot_load_sequencer: ADDR_W out of range");
    end

    // Command of a given step for a variant; slot step picks fallback
    function automatic drive_cmd_e step_cmd(input variant_e v, input logic [2:0] s,
                                            input logic alt_slot);
        drive_cmd_e c;
        c = CMD_NONE;
        case (v)
            VAR_FIXED_DISK:
                c = (s == 3'd0) ? CMD_READ : CMD_NONE; // [RULE_03]
            VAR_DISKETTE:
                case (s) // [RULE_08]
                    3'd0:    c = CMD_RECALIBRATE;
                    3'd1:    c = CMD_LOAD_HEADS;
                    3'd2:    c = CMD_READ;
                    default: c = CMD_NONE;
                endcase
            VAR_MAGAZINE:
                case (s)
                    3'd0:    c = CMD_ORIENT; // [RULE_10]
                    3'd1:    c = alt_slot ? CMD_SELECT_IO_SLOT : CMD_SELECT_MAGAZINE; // [RULE_11]
                    3'd2:    c = CMD_RECALIBRATE; // [RULE_12]
                    3'd3:    c = CMD_LOAD_HEADS;
                    3'd4:    c = CMD_READ;
                    default: c = CMD_NONE;
                endcase
            default: c = CMD_NONE;
        endcase
        return c;
    endfunction

    function automatic logic request_active(input variant_e v, input logic disk_n,
                                            input logic dskt_n);
        return (v == VAR_FIXED_DISK) ? !disk_n : !dskt_n;
    endfunction

    seq_state_e       state_reg, state_next;
    logic [2:0]       step_reg, step_next;
    logic             alt_reg, alt_next;
    logic [REC_W-1:0] rec_reg, rec_next;
    drive_cmd_e       code_reg, code_next;
    logic             done_reg, done_next;
    logic             csv_reg, csv_next;
    logic [7:0]       csd_reg, csd_next;
    logic             restart;
    logic             req;
    logic             reset_seen;
    drive_cmd_e       cur_cmd;

    assign req        = request_active(variant, first_disk_boot_request_n,
                                       diskette_boot_request_n);
    assign reset_seen = (variant == VAR_FIXED_DISK) ? !drive_reset_n // [RULE_01]
                                                    : !power_on_reset_n; // [RULE_05]
    assign cur_cmd    = step_cmd(variant, step_reg, alt_reg);
    assign restart    = (state_reg == ST_WAIT_REQUEST) && req;

    always_comb
    begin
        state_next = state_reg;
        step_next  = step_reg;
        alt_next   = alt_reg;
        rec_next   = rec_reg;
        code_next  = code_reg;
        done_next  = done_reg;
        csv_next   = 1'b0;
        csd_next   = csd_reg;
        case (state_reg)
            ST_WAIT_RESET:
                if (reset_seen)
                    state_next = ST_WAIT_REQUEST;
            ST_WAIT_REQUEST:
                if (req) // [RULE_02] [RULE_06]
                begin
                    state_next = ST_ISSUE;
                    step_next  = 3'd0;
                    alt_next   = 1'b0;
                    rec_next   = '0;
                    done_next  = 1'b0;
                    code_next  = step_cmd(variant, 3'd0, 1'b0); // [RULE_07]
                end
            ST_ISSUE:
                if (cmd_ready)
                begin
                    code_next  = CMD_NONE;
                    state_next = (cur_cmd == CMD_READ) ? ST_READ : ST_WAIT_DONE;
                end
            ST_WAIT_DONE:
                if (cmd_done)
                begin
                    // Empty magazine slot: retry the selection on the I/O slot
                    if (cur_cmd == CMD_SELECT_MAGAZINE && no_diskette) // [RULE_11]
                    begin
                        alt_next  = 1'b1;
                        code_next = CMD_SELECT_IO_SLOT;
                    end
                    else
                    begin
                        step_next = step_reg + 3'd1;
                        code_next = step_cmd(variant, step_reg + 3'd1, alt_reg);
                    end
                    state_next = ST_ISSUE;
                end
            ST_READ:
            begin
                if (rd_valid) // [RULE_15]
                begin
                    csv_next = 1'b1;
                    csd_next = rd_data;
                end
                if (rd_valid && rd_record_end)
                    rec_next = rec_reg + {{(REC_W-1){1'b0}}, 1'b1};
                if (variant == VAR_FIXED_DISK)
                begin
                    if (rd_valid && rd_record_end
                        && rec_reg == REC_W'(RECORD_COUNT - 1)) // [RULE_17]
                        state_next = ST_FINISH;
                end
                else if (!req) // [RULE_13]
                    state_next = ST_FINISH;
            end
            ST_FINISH:
            begin
                // Hold done until the channel raises its next request
                done_next = 1'b1; // [RULE_14]
                if (!req)
                    state_next = ST_WAIT_REQUEST;
            end
            default:
                state_next = ST_WAIT_RESET;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_reg <= ST_WAIT_RESET;
            step_reg  <= 3'd0;
            alt_reg   <= 1'b0;
            rec_reg   <= '0;
            code_reg  <= CMD_NONE;
            done_reg  <= 1'b0;
            csv_reg   <= 1'b0;
            csd_reg   <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            step_reg  <= step_next;
            alt_reg   <= alt_next;
            rec_reg   <= rec_next;
            code_reg  <= code_next;
            done_reg  <= done_next;
            csv_reg   <= csv_next;
            csd_reg   <= csd_next;
        end
    end

    // Address advances on each forwarded byte; the channel counts the total
    boot_store_addr #(
        .ADDR_W (ADDR_W)
    ) u_addr (
        .clk     (clk),
        .reset_n (reset_n),
        .restart (restart),
        .advance (csv_reg),
        .addr    (cs_addr)
    );

    // Start position is constant; drive is trusted to walk forward from it
    assign cmd_valid    = (state_reg == ST_ISSUE);
    assign cmd_code     = code_reg;
    assign cmd_cylinder = START_CYLINDER; // [RULE_03] [RULE_09]
    assign cmd_head     = START_HEAD;
    assign cmd_sector   = (variant == VAR_FIXED_DISK) ? START_RECORD : START_SECTOR;
    assign cmd_count    = (variant == VAR_FIXED_DISK) ? 8'(RECORD_COUNT) : 8'h00;
    assign cmd_slot     = alt_reg ? IO_SLOT : MAGAZINE_SLOT;
    assign cs_valid     = csv_reg;
    assign cs_data      = csd_reg;
    assign boot_busy    = (state_reg != ST_WAIT_RESET) && (state_reg != ST_WAIT_REQUEST);
    assign boot_done    = done_reg;

    logic unused_ok;
    assign unused_ok = microcode_load_cycle_n ^ (^MAGAZINE_NUMBER);
endmodule
`default_nettype wire

//--- test/boot_load_props.sv
// Purpose: Port assertions for the boot-load sequencer
// Assumes: Bound to every sequencer instance
// Notes:   Address model restarts whenever the sequencer is idle
`timescale 1ns/1ps
`default_nettype none
module boot_load_props
    import boot_load_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // Channel side
    input  wire boot_load_pkg::variant_e  variant,
    input  wire logic                     first_disk_boot_request_n,
    input  wire logic                     diskette_boot_request_n,
    // Drive side
    input  wire logic                     cmd_valid,
    input  wire boot_load_pkg::drive_cmd_e cmd_code,
    input  wire logic                     cmd_ready,
    input  wire logic [7:0]               cmd_sector,
    input  wire logic [7:0]               cmd_count,
    input  wire logic                     rd_valid,
    input  wire logic [7:0]               rd_data,
    // Storage and status
    input  wire logic                     cs_valid,
    input  wire logic [7:0]               cs_data,
    input  wire logic [ADDR_W-1:0]        cs_addr,
    input  wire logic                     boot_busy,
    input  wire logic                     boot_done
);
    logic [ADDR_W-1:0] exp_addr_reg;
    logic [ADDR_W-1:0] exp_addr_next;

    always_comb
        exp_addr_next = !boot_busy ? '0 : (cs_valid ? exp_addr_reg + 1'b1 : exp_addr_reg);
    always_ff @(posedge clk)
        exp_addr_reg <= !reset_n ? '0 : exp_addr_next;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_byte_forward: assert property (cs_valid |-> $past(rd_valid) && cs_data == $past(rd_data))
        else $error("stored byte not the drive byte");
    chk_addr_order: assert property (cs_valid |-> cs_addr == exp_addr_reg)
        else $error("storage address out of order");
    chk_disk_read: assert property (cmd_valid && cmd_code == CMD_READ && variant == VAR_FIXED_DISK
        |-> cmd_count == 8'h10 && cmd_sector == 8'h00)
        else $error("disk read parameters wrong");
    chk_dskt_read: assert property (cmd_valid && cmd_code == CMD_READ && variant != VAR_FIXED_DISK
        |-> cmd_sector == 8'h01)
        else $error("diskette read sector wrong");
    chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code))
        else $error("command withdrawn before accept");
    chk_wait_req: assert property (!boot_busy && (variant == VAR_FIXED_DISK ?
        first_disk_boot_request_n : diskette_boot_request_n) |=> !cmd_valid)
        else $error("command without load request");
    chk_orient_first: assert property (variant == VAR_MAGAZINE && cmd_valid && !$past(boot_busy)
        |-> cmd_code == CMD_ORIENT)
        else $error("magazine series not opened by orient");
    chk_mag_stop: assert property (variant == VAR_MAGAZINE && $rose(diskette_boot_request_n)
        |-> ##[1:4] !boot_busy)
        else $error("magazine read not stopped");
    chk_done_idle: assert property (boot_done |-> !cmd_valid)
        else $error("command offered after completion");
    chk_done_hold: assert property (boot_done && !first_disk_boot_request_n
        && variant == VAR_FIXED_DISK |=> boot_done)
        else $error("completion dropped under request");

    cp_disk_done: cover property (variant == VAR_FIXED_DISK && $rose(boot_done));
    cp_io_slot: cover property (cmd_valid && cmd_code == CMD_SELECT_IO_SLOT);
    cp_mag_data: cover property (variant == VAR_MAGAZINE && cs_valid);
endmodule

bind storage_boot_load_sequencer boot_load_props #(.ADDR_W(ADDR_W)) i_props (
    .clk(clk), .reset_n(reset_n), .variant(variant),
    .first_disk_boot_request_n(first_disk_boot_request_n),
    .diskette_boot_request_n(diskette_boot_request_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .cmd_sector(cmd_sector), .cmd_count(cmd_count),
    .rd_valid(rd_valid), .rd_data(rd_data), .cs_valid(cs_valid), .cs_data(cs_data),
    .cs_addr(cs_addr), .boot_busy(boot_busy), .boot_done(boot_done));
`default_nettype wire

//--- test/drive_model.sv
// Purpose: Behavioural disk or diskette drive for the sequencer
// Assumes: Commands arrive one at a time
// Notes:   Random accept and finish delays; data is a byte count
`timescale 1ns/1ps
`default_nettype none
module drive_model
    import boot_load_pkg::*;
#(
    parameter int REC_BYTES = 4
)
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // Sequencer side
    input  wire logic                      cmd_valid,
    input  wire boot_load_pkg::drive_cmd_e cmd_code,
    input  wire logic [7:0]                cmd_count,
    input  wire logic                      boot_busy,
    input  wire logic                      slot_empty,
    output logic                           cmd_ready,
    output logic                           cmd_done,
    output logic                           no_diskette,
    output logic                           rd_valid,
    output logic [7:0]                     rd_data,
    output logic                           rd_record_end
);
    integer seed = 32'h5e11;
    logic   reading;
    logic   fixed;
    int     wait_cnt;
    int     nbyte;

    assign no_diskette = slot_empty;
    always @(posedge clk)
    begin
        cmd_done <= 1'b0;
        rd_valid <= 1'b0;
        rd_record_end <= 1'b0;
        rd_data <= ~rd_data;
        if (!reset_n)
        begin
            cmd_ready <= 1'b0;
            reading <= 1'b0;
            wait_cnt <= 0;
            rd_data <= 8'h00;
        end
        else if (cmd_valid && cmd_ready)
        begin
            cmd_ready <= 1'b0;
            reading <= (cmd_code == CMD_READ);
            fixed <= (cmd_count == 8'h10);
            nbyte <= 0;
            wait_cnt <= (cmd_code == CMD_READ) ? 0 : ($random(seed) & 3) + 2;
        end
        else
        begin
            cmd_ready <= cmd_valid && ($random(seed) % 3 != 0);
            if (wait_cnt > 0)
            begin
                wait_cnt <= wait_cnt - 1;
                cmd_done <= (wait_cnt == 1);
            end
            // Records go out in order from record 0, with gaps
            if (reading && boot_busy && $random(seed) % 2 == 0)
            begin
                rd_valid <= 1'b1;
                rd_data <= 8'(nbyte);
                rd_record_end <= (nbyte % REC_BYTES == REC_BYTES - 1);
                nbyte <= nbyte + 1;
                if (fixed && nbyte == 16 * REC_BYTES - 1)
                    reading <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/tb.sv
// Purpose: Self-checking bench for the boot-load sequencer
// Assumes: Drive model answers every command
// Notes:   Short records keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb;
    import boot_load_pkg::*;
    typedef drive_cmd_e cmd_q_t[$];
    localparam int REC_BYTES = 4;
    logic clk, reset_n, drive_reset_n, power_on_reset_n, first_disk_boot_request_n;
    logic diskette_boot_request_n, microcode_load_cycle_n, slot_empty, no_diskette;
    logic cmd_valid, cmd_ready, cmd_done, rd_valid, rd_record_end, cs_valid, boot_busy, boot_done;
    logic [7:0] cmd_cylinder, cmd_sector, cmd_count, cmd_slot, rd_data, cs_data;
    logic [3:0] cmd_head;
    logic [15:0] cs_addr;
    variant_e variant;
    drive_cmd_e cmd_code;
    integer seed = 32'hfa53;
    int num_errors, cmp_count, cycles, nbytes;
    cmd_q_t got_q;

    storage_boot_load_sequencer i_dut (.clk, .reset_n, .variant, .drive_reset_n,
        .power_on_reset_n, .first_disk_boot_request_n, .diskette_boot_request_n,
        .microcode_load_cycle_n, .cmd_valid, .cmd_code, .cmd_cylinder, .cmd_head, .cmd_sector,
        .cmd_count, .cmd_slot, .cmd_ready, .cmd_done, .no_diskette, .rd_valid, .rd_data,
        .rd_record_end, .cs_valid, .cs_data, .cs_addr, .boot_busy, .boot_done);
    drive_model #(.REC_BYTES(REC_BYTES)) i_drive (.clk, .reset_n, .cmd_valid, .cmd_code,
        .cmd_count, .boot_busy, .slot_empty, .cmd_ready, .cmd_done, .no_diskette, .rd_valid,
        .rd_data, .rd_record_end);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic cmd_q_t exp_cmds(input variant_e v, input logic e);
        cmd_q_t q;
        q = {};
        if (v == VAR_MAGAZINE)
            q = {CMD_ORIENT, CMD_SELECT_MAGAZINE};
        if (v == VAR_MAGAZINE && e)
            q.push_back(CMD_SELECT_IO_SLOT);
        if (v != VAR_FIXED_DISK)
            q = {q, CMD_RECALIBRATE, CMD_LOAD_HEADS};
        q.push_back(CMD_READ);
        return q;
    endfunction

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cmd_valid && cmd_ready)
        begin
            got_q.push_back(cmd_code);
            if (cmd_code == CMD_READ)
                check({cmd_cylinder, cmd_head}, 0);
            if (cmd_code == CMD_SELECT_MAGAZINE || cmd_code == CMD_SELECT_IO_SLOT)
                check(cmd_slot, 8'h01);
        end
        if (cs_valid)
        begin
            check({cs_addr, cs_data}, {16'(nbytes), 8'(nbytes)});
            nbytes++;
        end
        // Last in the process: nothing may run after the verdict
        if (cycles == 30000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic boot(input variant_e v, input logic e);
        cmd_q_t exp_q;
        int lim;
        exp_q = exp_cmds(v, e);
        lim = (v == VAR_FIXED_DISK) ? 16 * REC_BYTES : 8 + ($random(seed) & 31);
        variant = v;
        slot_empty = e;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        got_q = {};
        nbytes = 0;
        @(posedge clk) #1;
        if (v == VAR_FIXED_DISK)
            drive_reset_n = 1'b0;
        else
            power_on_reset_n = 1'b0;
        @(posedge clk) #1;
        drive_reset_n = 1'b1;
        power_on_reset_n = 1'b1;
        microcode_load_cycle_n = 1'b0;
        if (v == VAR_FIXED_DISK)
            first_disk_boot_request_n = 1'b0;
        else
            diskette_boot_request_n = 1'b0;
        // Sample and drive 1 ns after the edge, never in the edge's own step
        for (int k = 0; k < 4000 && nbytes < lim; k++)
            @(posedge clk) #1;
        repeat (3) @(posedge clk);
        #1;
        if (v == VAR_FIXED_DISK)
            check(boot_done, 1'b1);
        microcode_load_cycle_n = 1'b1;
        first_disk_boot_request_n = 1'b1;
        diskette_boot_request_n = 1'b1;
        for (int k = 0; k < 20 && boot_busy !== 1'b0; k++)
            @(posedge clk) #1;
        check(boot_busy, 1'b0);
        check(got_q.size(), exp_q.size());
        foreach (exp_q[i])
            check(i < got_q.size() ? got_q[i] : CMD_NONE, exp_q[i]);
        if (v == VAR_FIXED_DISK)
            check(nbytes, lim);
        else
            check(nbytes >= lim, 1'b1);
    endtask

    initial
    begin
        {drive_reset_n, power_on_reset_n, first_disk_boot_request_n} = 3'h7;
        {diskette_boot_request_n, microcode_load_cycle_n, slot_empty} = 3'h6;
        variant = VAR_FIXED_DISK;
        reset_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        // Wrong reset level must not arm the disk sequence
        power_on_reset_n = 1'b0;
        @(posedge clk) #1 power_on_reset_n = 1'b1;
        first_disk_boot_request_n = 1'b0;
        repeat (10) @(posedge clk) #1;
        check(cmd_valid, 1'b0);
        first_disk_boot_request_n = 1'b1;
        for (int i = 0; i < 9; i++)
            boot(variant_e'(i % 3), (i == 2) ? 1'b0 : (i == 5) ? 1'b1 : 1'($random(seed)));
        end_of_test();
    end
endmodule
`default_nettype wire
